//--- rtl/relay_map_pkg.sv
`default_nettype none

package relay_map_pkg;

	// ----------------------------------------------------------------
	// Function codes and exception codes
	// ----------------------------------------------------------------
	localparam logic [7:0] FN_READ_REG = 8'h03;
	localparam logic [7:0] FN_WRITE_COIL = 8'h05;
	localparam logic [7:0] FN_WRITE_REG = 8'h06;
	localparam logic [7:0] FN_WRITE_MULTI = 8'h10;
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
	localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
	localparam logic [7:0] EXC_ILL_VALUE = 8'h03;

	// ----------------------------------------------------------------
	// Map, in one-based numbers; frame address is number minus one
	// ----------------------------------------------------------------
	localparam logic [15:0] NUM_TO_ADDR = 16'h0001;
	localparam logic [15:0] RELAY_REG_NUM = 16'h0001;
	localparam logic [15:0] CFG_FIRST_NUM = 16'h0101;
	localparam logic [15:0] CFG_LAST_NUM = 16'h0200;
	localparam logic [15:0] COIL_FIRST_NUM = 16'h0001;
	localparam logic [15:0] COIL_LAST_NUM = 16'h0006;
	localparam logic [15:0] COIL_ON = 16'hff00;
	localparam logic [15:0] COIL_OFF = 16'h0000;
	localparam int NUM_RELAYS = 6;

	// ----------------------------------------------------------------
	// Configuration area layout, byte indices
	// ----------------------------------------------------------------
	localparam int CFG_BYTES = 256;
	localparam logic [7:0] IDX_TYPE = 8'h00;
	localparam logic [7:0] IDX_VERSION = 8'h01;
	localparam logic [7:0] IDX_SERIAL_HI = 8'h02;
	localparam logic [7:0] IDX_SERIAL_LO = 8'h03;
	localparam logic [7:0] IDX_ID_LAST = 8'h03;
	localparam logic [7:0] IDX_OTP_LAST = 8'h0f;
	localparam logic [7:0] IDX_STARTUP = 8'h10;
	localparam logic [7:0] IDX_MODE = 8'h11;
	localparam logic [7:0] IDX_STATION = 8'h12;
	localparam int MODE_BAUD_BIT = 0;
	localparam int MODE_PARITY_BIT = 7;
	localparam logic [7:0] ERASED = 8'hff;
	localparam logic [7:0] STARTUP_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] FREE_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Jumper defaults and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] JUMPER_STATION = 8'hff;
	localparam logic JUMPER_BAUD_9600 = 1'b0;
	localparam logic JUMPER_PARITY_NONE = 1'b0;
	localparam int CLK_HZ = 10_000_000;
	localparam int IDLE_TIME_MS = 5000;
	localparam int IDLE_CYCLES = IDLE_TIME_MS * (CLK_HZ / 1000);

endpackage : relay_map_pkg

`default_nettype wire

//--- rtl/idle_watchdog.sv
`default_nettype none

module idle_watchdog #(
	parameter int IDLE_CYCLES = relay_map_pkg::IDLE_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic frame_ok_i,
	output logic expire_o
);

	localparam int CW = $clog2(IDLE_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(IDLE_CYCLES - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic expire;
	} wd_state_t;

	wd_state_t st_r;
	wd_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.expire = 1'b0;
		if (frame_ok_i) begin
			st_nxt.cnt = '0;
		end else if (st_r.cnt == LAST) begin
			st_nxt.cnt = '0;
			st_nxt.expire = 1'b1; // see R2
		end else begin
			st_nxt.cnt = st_r.cnt + CW'(1);
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign expire_o = st_r.expire;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);

	property p_frame_restarts;
		frame_ok_i |=> (st_r.cnt == '0) && !expire_o;
	endproperty
	a_frame_restarts: assert property (p_frame_restarts) // see R2
		else $error("valid frame did not restart idle count");

endmodule : idle_watchdog

`default_nettype wire

//--- rtl/config_store.sv
`default_nettype none

module config_store #(
	parameter logic [7:0] DEVICE_TYPE = 8'h5a, // Arbitrary value
	parameter logic [7:0] FW_VERSION = 8'h02,
	parameter logic [7:0] SERIAL_HI = 8'h00, // Arbitrary value
	parameter logic [7:0] SERIAL_LO = 8'h00, // Arbitrary value
	parameter logic [7:0] STATION_RESET = 8'h01
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic we_i,
	input wire logic [7:0] idx_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rd_data_o,
	output logic [7:0] startup_o,
	output logic [7:0] mode_o,
	output logic [7:0] station_o
);

	typedef logic [relay_map_pkg::CFG_BYTES-1:0][7:0] mem_t;
	typedef struct packed {
		mem_t mem;
	} cfg_state_t;

	function automatic mem_t init_mem();
		mem_t m;
		for (int i = 0; i < relay_map_pkg::CFG_BYTES; i++) begin
			m[i] = relay_map_pkg::FREE_RESET;
			if (i <= int'(relay_map_pkg::IDX_OTP_LAST)) begin
				m[i] = relay_map_pkg::ERASED;
			end
		end
		m[relay_map_pkg::IDX_TYPE] = DEVICE_TYPE; // see R12
		m[relay_map_pkg::IDX_VERSION] = FW_VERSION;
		m[relay_map_pkg::IDX_SERIAL_HI] = SERIAL_HI;
		m[relay_map_pkg::IDX_SERIAL_LO] = SERIAL_LO;
		m[relay_map_pkg::IDX_STARTUP] = relay_map_pkg::STARTUP_RESET;
		m[relay_map_pkg::IDX_MODE] = relay_map_pkg::MODE_RESET;
		m[relay_map_pkg::IDX_STATION] = STATION_RESET;
		return m;
	endfunction : init_mem

	localparam mem_t INIT = init_mem();

	cfg_state_t st_r;
	cfg_state_t st_nxt;
	logic writable;

	always_comb begin
		st_nxt = st_r;
		// Identity bytes never change, rest of low area only once
		writable = (idx_i > relay_map_pkg::IDX_ID_LAST) && // see R16
			((idx_i > relay_map_pkg::IDX_OTP_LAST) ||
			(st_r.mem[idx_i] == relay_map_pkg::ERASED)); // see R11
		if (we_i && writable) begin
			st_nxt.mem[idx_i] = wdata_i; // see R10
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '{mem: INIT};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_data_o = st_r.mem[idx_i];
	assign startup_o = st_r.mem[relay_map_pkg::IDX_STARTUP];
	assign mode_o = st_r.mem[relay_map_pkg::IDX_MODE];
	assign station_o = st_r.mem[relay_map_pkg::IDX_STATION];

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);

	property p_otp_frozen;
		we_i && (idx_i <= relay_map_pkg::IDX_OTP_LAST) &&
			(st_r.mem[idx_i] != relay_map_pkg::ERASED)
			|=> st_r.mem[$past(idx_i)] == $past(rd_data_o);
	endproperty
	a_otp_frozen: assert property (p_otp_frozen) // see R11
		else $error("frozen one-time byte was changed");

	property p_id_fixed;
		st_r.mem[relay_map_pkg::IDX_TYPE] == DEVICE_TYPE &&
			st_r.mem[relay_map_pkg::IDX_SERIAL_LO] == SERIAL_LO;
	endproperty
	a_id_fixed: assert property (p_id_fixed) // see R16
		else $error("identity byte was overwritten");

	property p_free_write;
		we_i && (idx_i > relay_map_pkg::IDX_OTP_LAST)
			|=> st_r.mem[$past(idx_i)] == $past(wdata_i);
	endproperty
	a_free_write: assert property (p_free_write) // see R11
		else $error("free configuration byte not written");

endmodule : config_store

`default_nettype wire

//--- rtl/relay_map.sv
// Notes on behaviour
// R1 - Jumper forces defaults within 5 s
// R2 - 5 s idle reloads stored serial setup
// R3 - Jumper: 19200 even, station 255
// R4 - Full 64k space; unmapped answers exception
// R5 - Only coils and registers; no discrete reads
// R6 - Frame address is number minus one
// R7 - Coils 1..6 drive relays; others rejected
// R8 - Register 1 write sets all relays
// R9 - Coil/register writes; register read returns relays
// R10 - 256 config bytes at registers 257..512
// R11 - First 16 bytes writable only while 0xff
// R12 - Low area: type, version, serial, installer
// R13 - Mode bit0 9600, bit7 no parity
// R14 - Next register holds station address
// R15 - Startup byte resets zero, sets relays
// R16 - Identity bytes are read-only
`default_nettype none

module relay_map #(
	parameter int IDLE_CYCLES = relay_map_pkg::IDLE_CYCLES,
	parameter logic [7:0] DEVICE_TYPE = 8'h5a, // Arbitrary value
	parameter logic [7:0] FW_VERSION = 8'h02,
	parameter logic [7:0] SERIAL_HI = 8'h00, // Arbitrary value
	parameter logic [7:0] SERIAL_LO = 8'h00, // Arbitrary value
	parameter logic [7:0] STATION_RESET = 8'h01
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic default_config_jumper_i,
	input wire logic frame_ok_i,
	input wire logic req_valid_i,
	input wire logic [7:0] req_func_i,
	input wire logic [15:0] req_addr_i,
	input wire logic [15:0] req_data_i,
	output logic rsp_valid_o,
	output logic rsp_exc_o,
	output logic [7:0] rsp_exc_code_o,
	output logic [15:0] rsp_data_o,
	output logic [5:0] relay_o,
	output logic baud_9600_o,
	output logic parity_none_o,
	output logic [7:0] station_addr_o,
	output logic serial_reset_o
);

	// ----------------------------------------------------------------
	// Address decoding
	// ----------------------------------------------------------------
	localparam logic [15:0] RELAY_ADDR =
		relay_map_pkg::RELAY_REG_NUM - relay_map_pkg::NUM_TO_ADDR;
	localparam logic [15:0] CFG_FIRST =
		relay_map_pkg::CFG_FIRST_NUM - relay_map_pkg::NUM_TO_ADDR;
	localparam logic [15:0] CFG_LAST =
		relay_map_pkg::CFG_LAST_NUM - relay_map_pkg::NUM_TO_ADDR;
	localparam logic [15:0] COIL_FIRST =
		relay_map_pkg::COIL_FIRST_NUM - relay_map_pkg::NUM_TO_ADDR;
	localparam logic [15:0] COIL_LAST =
		relay_map_pkg::COIL_LAST_NUM - relay_map_pkg::NUM_TO_ADDR;

	function automatic logic is_cfg(input logic [15:0] a);
		return (a >= CFG_FIRST) && (a <= CFG_LAST); // see R6
	endfunction : is_cfg

	function automatic logic [7:0] cfg_idx(input logic [15:0] a);
		logic [15:0] d;
		d = a - CFG_FIRST;
		return d[7:0];
	endfunction : cfg_idx

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_BOOT = 2'b00,
		ST_RUN = 2'b01
	} phase_t;

	typedef struct packed {
		phase_t phase;
		logic jmp_s1;
		logic jmp_s2;
		logic jmp_prev;
		logic [5:0] relays;
		logic rsp_valid;
		logic rsp_exc;
		logic [7:0] rsp_code;
		logic [15:0] rsp_data;
		logic baud_9600;
		logic parity_none;
		logic [7:0] station;
		logic ser_rst;
	} map_state_t;

	map_state_t st_r;
	map_state_t st_nxt;
	logic cfg_we;
	logic [7:0] cfg_wdata;
	logic [7:0] cfg_rd;
	logic [7:0] cfg_startup;
	logic [7:0] cfg_mode;
	logic [7:0] cfg_station;
	logic idle_expire;
	logic reload;

	config_store #(
		.DEVICE_TYPE(DEVICE_TYPE),
		.FW_VERSION(FW_VERSION),
		.SERIAL_HI(SERIAL_HI),
		.SERIAL_LO(SERIAL_LO),
		.STATION_RESET(STATION_RESET)
	) u_cfg (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.we_i(cfg_we),
		.idx_i(cfg_idx(req_addr_i)),
		.wdata_i(cfg_wdata),
		.rd_data_o(cfg_rd),
		.startup_o(cfg_startup),
		.mode_o(cfg_mode),
		.station_o(cfg_station)
	);

	idle_watchdog #(
		.IDLE_CYCLES(IDLE_CYCLES)
	) u_idle (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.frame_ok_i(frame_ok_i),
		.expire_o(idle_expire)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		cfg_we = 1'b0;
		cfg_wdata = req_data_i[7:0];
		st_nxt.jmp_s1 = default_config_jumper_i;
		st_nxt.jmp_s2 = st_r.jmp_s1;
		st_nxt.jmp_prev = st_r.jmp_s2;
		st_nxt.rsp_valid = 1'b0;
		// Serial setup: jumper overrides, else reload at boot, on idle or removal
		st_nxt.ser_rst = idle_expire || (st_r.jmp_s2 != st_r.jmp_prev);
		reload = (st_r.phase == ST_BOOT) || idle_expire || // see R2
			(st_r.jmp_prev && !st_r.jmp_s2); // see R1
		if (st_r.jmp_s2) begin
			st_nxt.baud_9600 = relay_map_pkg::JUMPER_BAUD_9600; // see R3
			st_nxt.parity_none = relay_map_pkg::JUMPER_PARITY_NONE;
			st_nxt.station = relay_map_pkg::JUMPER_STATION;
		end else if (reload) begin
			st_nxt.baud_9600 =
				cfg_mode[relay_map_pkg::MODE_BAUD_BIT]; // see R13
			st_nxt.parity_none = cfg_mode[relay_map_pkg::MODE_PARITY_BIT];
			st_nxt.station = cfg_station; // see R14
		end
		case (st_r.phase)
			ST_BOOT: begin
				st_nxt.relays = cfg_startup[5:0]; // see R15
				st_nxt.phase = ST_RUN;
			end
			ST_RUN: begin
				if (req_valid_i) begin
					st_nxt.rsp_valid = 1'b1;
					st_nxt.rsp_exc = 1'b0;
					st_nxt.rsp_code = relay_map_pkg::EXC_NONE;
					st_nxt.rsp_data = req_data_i;
					case (req_func_i)
						relay_map_pkg::FN_READ_REG: begin
							if (req_addr_i == RELAY_ADDR) begin
								st_nxt.rsp_data = {10'h000, st_r.relays}; // see R9
							end else if (is_cfg(req_addr_i)) begin
								st_nxt.rsp_data = {8'h00, cfg_rd}; // see R10
							end else begin
								st_nxt.rsp_exc = 1'b1; // see R4
								st_nxt.rsp_code = relay_map_pkg::EXC_ILL_ADDR;
							end
						end
						relay_map_pkg::FN_WRITE_COIL: begin
							if (req_addr_i < COIL_FIRST || req_addr_i > COIL_LAST) begin
								st_nxt.rsp_exc = 1'b1; // see R7
								st_nxt.rsp_code = relay_map_pkg::EXC_ILL_ADDR;
							end else if (req_data_i == relay_map_pkg::COIL_ON) begin
								st_nxt.relays[req_addr_i[2:0]] = 1'b1; // see R9
							end else if (req_data_i == relay_map_pkg::COIL_OFF) begin
								st_nxt.relays[req_addr_i[2:0]] = 1'b0;
							end else begin
								st_nxt.rsp_exc = 1'b1;
								st_nxt.rsp_code = relay_map_pkg::EXC_ILL_VALUE;
							end
						end
						relay_map_pkg::FN_WRITE_REG,
						relay_map_pkg::FN_WRITE_MULTI: begin
							if (req_addr_i == RELAY_ADDR) begin
								st_nxt.relays = req_data_i[5:0]; // see R8
							end else if (is_cfg(req_addr_i)) begin
								cfg_we = 1'b1; // see R10
							end else begin
								st_nxt.rsp_exc = 1'b1; // see R4
								st_nxt.rsp_code = relay_map_pkg::EXC_ILL_ADDR;
							end
						end
						default: begin
							st_nxt.rsp_exc = 1'b1; // see R5
							st_nxt.rsp_code = relay_map_pkg::EXC_ILL_FUNC;
						end
					endcase
				end
			end
			default: begin
				st_nxt.phase = ST_BOOT;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '{phase: ST_BOOT, rsp_code: relay_map_pkg::EXC_NONE,
				station: relay_map_pkg::JUMPER_STATION, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rsp_valid_o = st_r.rsp_valid;
	assign rsp_exc_o = st_r.rsp_exc;
	assign rsp_exc_code_o = st_r.rsp_code;
	assign rsp_data_o = st_r.rsp_data;
	assign relay_o = st_r.relays;
	assign baud_9600_o = st_r.baud_9600;
	assign parity_none_o = st_r.parity_none;
	assign station_addr_o = st_r.station;
	assign serial_reset_o = st_r.ser_rst;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);

	property p_jumper_defaults;
		st_r.jmp_s2 |=> station_addr_o == 8'hff && !baud_9600_o &&
			!parity_none_o;
	endproperty
	a_jumper_defaults: assert property (p_jumper_defaults) // see R3
		else $error("jumper defaults not applied");

	property p_jumper_fast;
		$rose(default_config_jumper_i) ##1 default_config_jumper_i[*3]
			|=> station_addr_o == 8'hff;
	endproperty
	a_jumper_fast: assert property (p_jumper_fast) // see R1
		else $error("jumper defaults late");

	property p_idle_reload;
		idle_expire && !st_r.jmp_s2 |=> serial_reset_o &&
			station_addr_o == $past(cfg_station) &&
			baud_9600_o == $past(cfg_mode[0]);
	endproperty
	a_idle_reload: assert property (p_idle_reload) // see R2
		else $error("idle timeout did not reload setup");

	property p_coil_reject;
		req_valid_i && st_r.phase == ST_RUN &&
			req_func_i == relay_map_pkg::FN_WRITE_COIL && req_addr_i > 16'h0005
			|=> rsp_valid_o && rsp_exc_o && relay_o == $past(relay_o);
	endproperty
	a_coil_reject: assert property (p_coil_reject) // see R7
		else $error("coil write beyond relay six accepted");

	property p_reg_write;
		req_valid_i && st_r.phase == ST_RUN && req_addr_i == 16'h0000 &&
			req_func_i == relay_map_pkg::FN_WRITE_REG
			|=> relay_o == $past(req_data_i[5:0]) && !rsp_exc_o;
	endproperty
	a_reg_write: assert property (p_reg_write) // see R8
		else $error("register write did not set relays");

	property p_reg_read;
		req_valid_i && st_r.phase == ST_RUN && req_addr_i == 16'h0000 &&
			req_func_i == relay_map_pkg::FN_READ_REG
			|=> rsp_data_o == {10'h000, $past(relay_o)} && !rsp_exc_o;
	endproperty
	a_reg_read: assert property (p_reg_read) // see R9
		else $error("relay read back wrong");

	property p_unmapped;
		req_valid_i && st_r.phase == ST_RUN &&
			req_func_i == relay_map_pkg::FN_READ_REG &&
			req_addr_i > 16'h0000 && req_addr_i < 16'h0100
			|=> rsp_exc_o && rsp_exc_code_o == 8'h02;
	endproperty
	a_unmapped: assert property (p_unmapped) // see R4
		else $error("unmapped read not answered with exception");

	property p_no_discrete;
		req_valid_i && st_r.phase == ST_RUN && req_func_i == 8'h02
			|=> rsp_exc_o && rsp_exc_code_o == 8'h01;
	endproperty
	a_no_discrete: assert property (p_no_discrete) // see R5
		else $error("discrete read not refused");

	property p_cfg_byte;
		req_valid_i && st_r.phase == ST_RUN && is_cfg(req_addr_i) &&
			req_func_i == relay_map_pkg::FN_READ_REG
			|=> rsp_data_o[15:8] == 8'h00 && !rsp_exc_o;
	endproperty
	a_cfg_byte: assert property (p_cfg_byte) // see R10
		else $error("configuration read not a byte");

	property p_boot_relays;
		st_r.phase == ST_BOOT |=> relay_o == $past(cfg_startup[5:0]);
	endproperty
	a_boot_relays: assert property (p_boot_relays) // see R15
		else $error("startup relays not loaded");

	c_coil_on: cover property (req_valid_i &&
		req_func_i == relay_map_pkg::FN_WRITE_COIL ##1 rsp_valid_o &&
		!rsp_exc_o);
	c_idle: cover property (idle_expire ##1 serial_reset_o);
	c_jumper_off: cover property ($fell(st_r.jmp_s2) ##1 serial_reset_o);

endmodule : relay_map

`default_nettype wire

//--- test/modbus_master_model.sv
`default_nettype none

module modbus_master_model (
	input wire logic ref_clk_i,
	input wire logic rsp_valid_i,
	input wire logic rsp_exc_i,
	input wire logic [7:0] rsp_exc_code_i,
	input wire logic [15:0] rsp_data_i,
	output logic frame_ok_o,
	output logic req_valid_o,
	output logic [7:0] req_func_o,
	output logic [15:0] req_addr_o,
	output logic [15:0] req_data_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		frame_ok_o = 1'b0;
		req_valid_o = 1'b0;
		req_func_o = 8'h00;
		req_addr_o = 16'h0000;
		req_data_o = 16'h0000;
	end

	// ----------------------------------------------------------------
	// One access by one-based number
	// ----------------------------------------------------------------
	task automatic xfer(input logic [7:0] func, input logic [15:0] num,
		input logic [15:0] data, output logic [7:0] code,
		output logic [15:0] rdata, output logic lost);
		@(negedge ref_clk_i);
		req_valid_o = 1'b1;
		frame_ok_o = 1'b1;
		req_func_o = func;
		req_addr_o = num - 16'h0001;
		req_data_o = data;
		@(negedge ref_clk_i);
		req_valid_o = 1'b0;
		frame_ok_o = 1'b0;
		// Released lines carry garbage, not the last value
		req_func_o = ~req_func_o;
		req_addr_o = ~req_addr_o;
		req_data_o = ~req_data_o;
		lost = (rsp_valid_i !== 1'b1)
			|| (rsp_exc_i !== (rsp_exc_code_i !== 8'h00));
		code = rsp_exc_code_i;
		rdata = rsp_data_i;
	endtask : xfer

endmodule : modbus_master_model

`default_nettype wire

//--- test/test_relay_map.sv
`default_nettype none

module test_relay_map;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int IDLE = 64;
	localparam logic [7:0] DEV_TYPE = 8'h3c; // Arbitrary value
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic jumper = 1'b0;
	logic frame_ok, req_valid, rsp_valid, rsp_exc, baud, parity, sreset;
	logic [7:0] req_func, rsp_code, station, code, v;
	logic [15:0] req_addr, req_data, rsp_data, rdata, num;
	logic [5:0] relay, shadow;
	logic lost;
	logic [31:0] seed = 32'h2dcbc172;
	logic [15:0] bad_num [4] = '{16'd2, 16'd256, 16'd513, 16'd0};
	logic [15:0] otp_num [3] = '{16'd261, 16'd265, 16'd272};
	int fails = 0;
	int checked = 0;
	int n;

	always #50 ref_clk_i = ~ref_clk_i;

	relay_map #(.IDLE_CYCLES(IDLE), .DEVICE_TYPE(DEV_TYPE),
		.FW_VERSION(8'h02), .SERIAL_HI(8'h11), .SERIAL_LO(8'h22),
		.STATION_RESET(8'h01)) i_relay_map (.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i), .default_config_jumper_i(jumper),
		.frame_ok_i(frame_ok), .req_valid_i(req_valid),
		.req_func_i(req_func), .req_addr_i(req_addr),
		.req_data_i(req_data), .rsp_valid_o(rsp_valid),
		.rsp_exc_o(rsp_exc), .rsp_exc_code_o(rsp_code),
		.rsp_data_o(rsp_data), .relay_o(relay), .baud_9600_o(baud),
		.parity_none_o(parity), .station_addr_o(station),
		.serial_reset_o(sreset));

	modbus_master_model i_master (.ref_clk_i(ref_clk_i),
		.rsp_valid_i(rsp_valid), .rsp_exc_i(rsp_exc),
		.rsp_exc_code_i(rsp_code), .rsp_data_i(rsp_data),
		.frame_ok_o(frame_ok), .req_valid_o(req_valid),
		.req_func_o(req_func), .req_addr_o(req_addr),
		.req_data_o(req_data));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : next_rand

	function automatic logic [15:0] relay_word(input logic [15:0] d);
		return {10'h000, d[5:0]};
	endfunction : relay_word

	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic acc(input logic [7:0] func, input logic [15:0] num,
		input logic [15:0] data, input logic [7:0] exp_code);
		i_master.xfer(func, num, data, code, rdata, lost);
		check("answer", 16'(lost), 16'h0000);
		check("exception", 16'(code), 16'(exp_code));
	endtask : acc

	task automatic wait_reset(input int lim);
		n = 0;
		// Step first so a pulse still standing is not counted again
		do begin
			@(negedge ref_clk_i);
			n++;
		end while (sreset !== 1'b1 && n < lim);
	endtask : wait_reset

	task automatic serial(input logic b, input logic p, input logic [7:0] s);
		check("serial pulse", 16'(sreset), 16'h0001);
		check("baud", 16'(baud), 16'(b));
		check("parity", 16'(parity), 16'(p));
		check("station", 16'(station), 16'(s));
	endtask : serial

	task automatic wrap_up;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up

	initial begin
		#(5000 * 100);
		fails++;
		$display("watchdog expired");
		wrap_up();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(negedge ref_clk_i);
		nrst_i = 1'b1;
		repeat (2) @(negedge ref_clk_i);
		check("relay", 16'(relay), 16'h0000);
		check("station", 16'(station), 16'h0001);
		check("baud", 16'(baud), 16'h0000);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			seed = next_rand(seed);
			acc(i[0] ? relay_map_pkg::FN_WRITE_MULTI
				: relay_map_pkg::FN_WRITE_REG, 16'd1, seed[15:0], 8'h00);
			check("relay", 16'(relay), relay_word(seed[15:0]));
			acc(relay_map_pkg::FN_READ_REG, 16'd1, 16'h0, 8'h00);
			check("relay read", rdata, relay_word(seed[15:0]));
		end
		shadow = seed[5:0];
		for (int c = 1; c <= 6; c++) begin
			for (int on = 1; on >= 0; on--) begin
				acc(relay_map_pkg::FN_WRITE_COIL, 16'(c), on ? 16'hff00
					: 16'h0000, 8'h00);
				shadow[c-1] = on[0];
				check("coil", 16'(relay), 16'(shadow));
			end
		end
		acc(relay_map_pkg::FN_WRITE_COIL, 16'd7, 16'hff00, 8'h02);
		acc(relay_map_pkg::FN_WRITE_COIL, 16'd1, 16'h1234, 8'h03);
		check("coil refused", 16'(relay), 16'(shadow));
		$display("test relays done");
		// Number 0 wraps to frame address ffff
		foreach (bad_num[k]) begin
			num = bad_num[k];
			acc(relay_map_pkg::FN_READ_REG, num, 16'h0, 8'h02);
			acc(relay_map_pkg::FN_WRITE_REG, num, 16'h5, 8'h02);
		end
		acc(8'h01, 16'd1, 16'h0, 8'h01);
		acc(8'h02, 16'd1, 16'h0, 8'h01);
		acc(8'h04, 16'd1, 16'h0, 8'h01);
		$display("test unmapped done");
		acc(relay_map_pkg::FN_WRITE_REG, 16'd257, 16'h0000, 8'h00);
		acc(relay_map_pkg::FN_READ_REG, 16'd257, 16'h0, 8'h00);
		check("type", rdata, {8'h00, DEV_TYPE});
		acc(relay_map_pkg::FN_READ_REG, 16'd260, 16'h0, 8'h00);
		check("serial", rdata, 16'h0022);
		foreach (otp_num[k]) begin
			num = otp_num[k];
			seed = next_rand(seed);
			v = {1'b0, seed[6:0]};
			acc(relay_map_pkg::FN_READ_REG, num, 16'h0, 8'h00);
			check("erased", rdata, 16'h00ff);
			acc(relay_map_pkg::FN_WRITE_REG, num, {8'h00, v}, 8'h00);
			acc(relay_map_pkg::FN_WRITE_REG, num, {8'h00, ~v}, 8'h00);
			acc(relay_map_pkg::FN_READ_REG, num, 16'h0, 8'h00);
			check("frozen", rdata, {8'h00, v});
		end
		for (int i = 0; i < 5; i++) begin
			seed = next_rand(seed);
			num = (i == 0) ? 16'd512 : 16'd276 + 16'(seed[23:16] % 237);
			acc(relay_map_pkg::FN_WRITE_REG, num, seed[15:0], 8'h00);
			acc(relay_map_pkg::FN_READ_REG, num, 16'h0, 8'h00);
			check("config byte", rdata, {8'h00, seed[7:0]});
		end
		$display("test config done");
		acc(relay_map_pkg::FN_WRITE_REG, 16'd274, 16'h0081, 8'h00);
		acc(relay_map_pkg::FN_WRITE_REG, 16'd275, 16'h0033, 8'h00);
		check("baud held", 16'(baud), 16'h0000);
		wait_reset(IDLE + 8);
		check("idle span", 16'(n >= IDLE - 4), 16'h0001);
		serial(1'b1, 1'b1, 8'h33);
		jumper = 1'b1;
		wait_reset(8);
		serial(1'b0, 1'b0, 8'hff);
		@(negedge ref_clk_i);
		wait_reset(IDLE + 8);
		serial(1'b0, 1'b0, 8'hff);
		@(negedge ref_clk_i);
		jumper = 1'b0;
		wait_reset(8);
		serial(1'b1, 1'b1, 8'h33);
		$display("test serial done");
		nrst_i = 1'b0;
		repeat (3) @(negedge ref_clk_i);
		nrst_i = 1'b1;
		repeat (2) @(negedge ref_clk_i);
		check("relay", 16'(relay), 16'h0000);
		check("station", 16'(station), 16'h0001);
		acc(relay_map_pkg::FN_READ_REG, 16'd273, 16'h0, 8'h00);
		check("startup", rdata, 16'h0000);
		$display("test second reset done");
		wrap_up();
	end

endmodule : test_relay_map

`default_nettype wire
